/* hw/smp_pkg.sv */
// Constants and types for the status monitor and host port block
package smp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REG_W = 16;
  localparam int REG_N = 32;
  localparam logic [4:0] REG_ROUTE = 5'h03;
  localparam logic [4:0] REG_CFG = 5'h04;
  localparam logic [4:0] REG_LOOP = 5'h15;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int RT_A_SEL = 12;
  localparam int RT_A_LOS = 11;
  localparam int RT_A_ULK = 10;
  localparam int RT_B_SEL = 9;
  localparam int RT_B_LOS = 8;
  localparam int RT_B_ULK = 7;
  localparam int CFG_SEC_EN = 5;
  localparam int CFG_SMART_EN = 6;
  localparam int CFG_STALL_ERR = 7;
  localparam int LP_SEL = 0;
  localparam int LP_LOS = 1;
  localparam int LP_ULK = 2;
  localparam logic [15:0] LOOP_WMASK = 16'h0000;
  localparam logic [3:0] DEV_ADDR = 4'h0;
  localparam logic [4:0] BIT_HDR_LAST = 5'h0f;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h10;
  localparam logic [4:0] BIT_DATA_LAST = 5'h1f;
  localparam logic [1:0] MODE_SPI = 2'h0;
  localparam logic [1:0] MODE_TWI = 2'h1;
  localparam logic [1:0] MODE_PIN = 2'h2;
  localparam logic [2:0] SLIP_LIMIT = 3'h4;
  localparam logic [9:0] UNLOCK_HOLD = 10'h3e8;
  localparam int STALL_NS = 2000;
  localparam int STALL_CYC_I = (STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] STALL_CYC = 16'(STALL_CYC_I);
  localparam logic [8:0] STALL_PAT_LOW = 9'h1ff;
  localparam logic [7:0] PSB_MAP = 8'hcc;
  typedef struct packed {
    logic rw;
    logic [3:0] dev;
    logic [10:0] addr;
  } smp_hdr_t;
  typedef struct packed {
    logic ref_sel;
    logic ref_loss;
    logic unlock;
  } smp_vitals_t;
  typedef enum {ST_IDLE, ST_HDR, ST_DATA} smp_spi_st_t;
endpackage

/* hw/smp_status_port.sv */
// Status pin mapping, lock detector, host port select and serial register port
`timescale 1ns/10ps
module smp_status_port (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_SELECT,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE,
  input wire logic [1:0] HOST_PORT_SEL,
  input wire logic [4:0] PRESET_SELECT_PINS,
  input wire logic PFD_REF_IN,
  input wire logic PFD_FB_IN,
  input wire logic REF_SELECT_IN,
  input wire logic REF_LOSS_IN,
  output logic STATUS_OUT_A,
  output logic STATUS_OUT_B,
  output logic SPI_MODE,
  output logic TWO_WIRE_MODE,
  output logic PIN_MODE,
  output logic [4:0] PRESET_CFG,
  output logic [7:0] PRESCALER_B_MAP
);
  localparam int NSYNC = 14;
  localparam int SEL_BIT = 1;
  localparam smp_pkg::smp_spi_st_t ST_IDLE = smp_pkg::ST_IDLE;
  localparam smp_pkg::smp_spi_st_t ST_HDR = smp_pkg::ST_HDR;
  localparam smp_pkg::smp_spi_st_t ST_DATA = smp_pkg::ST_DATA;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // Two-flop synchronisers for every pin input
  logic [NSYNC-1:0] raw, s1_q, s2_q;
  assign raw = {PRESET_SELECT_PINS, HOST_PORT_SEL, REF_LOSS_IN, REF_SELECT_IN,
                PFD_FB_IN, PFD_REF_IN, SERIAL_IN, SERIAL_SELECT, SERIAL_CLOCK};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (RESET) begin
          s1_q[g] <= (g == SEL_BIT); // Select idles high, no false frame
          s2_q[g] <= (g == SEL_BIT);
        end else if (CE) begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate
  logic sck_s, scs_s, sdi_s, ref_s, fb_s, rsel_s, rlos_s;
  logic [1:0] mode_s;
  logic [4:0] preset_s;
  assign {preset_s, mode_s, rlos_s, rsel_s, fb_s, ref_s, sdi_s, scs_s, sck_s} = s2_q;

  // Edge history of sampled clocks
  logic sck_p_q, ref_p_q, fb_p_q;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sck_p_q <= 1'b0;
      ref_p_q <= 1'b0;
      fb_p_q <= 1'b0;
    end else if (CE) begin
      sck_p_q <= sck_s;
      ref_p_q <= ref_s;
      fb_p_q <= fb_s;
    end
  end
  logic sck_rise, sck_fall, ref_e, fb_e;
  assign sck_rise = sck_s & ~sck_p_q;
  assign sck_fall = ~sck_s & sck_p_q;
  assign ref_e = ref_s & ~ref_p_q;
  assign fb_e = fb_s & ~fb_p_q;

  // Host port mode and pin-mode preset
  logic [1:0] mode_q, mode_d;
  logic [4:0] preset_q, preset_d;
  always_comb begin
    mode_d = mode_s;
    preset_d = preset_q;
    if (mode_s == smp_pkg::MODE_PIN) begin
      preset_d = preset_s;
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_q <= smp_pkg::MODE_SPI;
      preset_q <= 5'h00;
    end else if (CE) begin
      mode_q <= mode_d;
      preset_q <= preset_d;
    end
  end

  // Serial port frame engine and register file
  smp_pkg::smp_spi_st_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d, rd_q, rd_d;
  smp_pkg::smp_hdr_t hdr_q, hdr_d, hdr_n;
  logic sdo_q, sdo_d, oe_q, oe_d;
  logic [15:0] regs_q [smp_pkg::REG_N];
  logic [15:0] regs_d [smp_pkg::REG_N];
  logic [15:0] loop_word, wr_data;
  logic wr_en, spi_on, hit;
  logic [10:0] addr_inc;
  smp_pkg::smp_vitals_t vit_q, vit_d;

  function automatic logic [15:0] rd_word(input logic [10:0] a,
                                          input logic [15:0] r [smp_pkg::REG_N]);
    rd_word = (a[10:5] == 6'h00) ? r[a[4:0]] : 16'h0000;
  endfunction

  assign spi_on = (mode_q == smp_pkg::MODE_SPI);
  assign hit = (hdr_q.dev == smp_pkg::DEV_ADDR);
  assign addr_inc = 11'(hdr_q.addr + 11'h001);
  assign wr_data = {sh_q[14:0], sdi_s};
  assign hdr_n = {sh_q[14:0], sdi_s};
  assign wr_en = spi_on & ~scs_s & sck_rise & (st_q == ST_DATA) &
                 (cnt_q == smp_pkg::BIT_DATA_LAST) & ~hdr_q.rw & hit &
                 (hdr_q.addr[10:5] == 6'h00);
  assign loop_word = {13'h0000, vit_q.unlock, vit_q.ref_loss, vit_q.ref_sel};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rd_d = rd_q;
    hdr_d = hdr_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    for (int i = 0; i < smp_pkg::REG_N; i++) begin
      regs_d[i] = regs_q[i];
    end
    // Hardware owns the readback word; host writes are masked off
    regs_d[smp_pkg::REG_LOOP] = (loop_word & ~smp_pkg::LOOP_WMASK) |
                                (wr_data & smp_pkg::LOOP_WMASK);
    if (!spi_on || scs_s) begin
      st_d = ST_IDLE;
      cnt_d = 5'h00;
      oe_d = 1'b0;
      sdo_d = 1'b0;
    end else begin
      if (st_q == ST_IDLE) begin
        st_d = ST_HDR;
      end
      if (sck_rise) begin
        sh_d = {sh_q[14:0], sdi_s};
        if (st_q == ST_DATA) begin
          cnt_d = 5'(cnt_q + 5'h01);
          if (cnt_q == smp_pkg::BIT_DATA_LAST) begin
            if (wr_en && hdr_q.addr[4:0] != smp_pkg::REG_LOOP) begin
              regs_d[hdr_q.addr[4:0]] = wr_data;
            end
            hdr_d.addr = addr_inc;
            cnt_d = smp_pkg::BIT_DATA_FIRST;
            rd_d = rd_word(addr_inc, regs_q);
          end
        end else begin
          cnt_d = 5'(cnt_q + 5'h01);
          if (cnt_q == smp_pkg::BIT_HDR_LAST) begin
            hdr_d = hdr_n;
            st_d = ST_DATA;
            rd_d = rd_word(hdr_n.addr, regs_q);
          end
        end
      end else if (sck_fall && st_q == ST_DATA && hdr_q.rw && hit) begin
        sdo_d = rd_q[15];
        rd_d = {rd_q[14:0], 1'b0};
        oe_d = 1'b1;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      rd_q <= 16'h0000;
      hdr_q <= '0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      for (int i = 0; i < smp_pkg::REG_N; i++) begin
        regs_q[i] <= smp_pkg::REG_RESET;
      end
    end else if (CE) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      hdr_q <= hdr_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      for (int i = 0; i < smp_pkg::REG_N; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  sequence s_word_done;
    CE && spi_on && !scs_s && sck_rise && st_q == ST_DATA && cnt_q == smp_pkg::BIT_DATA_LAST;
  endsequence
  sequence s_next_word(logic [10:0] a);
    hdr_q.addr == a && cnt_q == smp_pkg::BIT_DATA_FIRST && st_q == ST_DATA;
  endsequence
  a_addr_step: assert property (s_word_done |=> s_next_word($past(addr_inc)))
    else $error("address pointer did not advance after data word");
  a_abort_idle: assert property ((CE && scs_s) |=> (st_q == ST_IDLE && cnt_q == 5'h00))
    else $error("deselect did not abort the frame");
  a_oe_off: assert property ((CE && scs_s) |=> !SERIAL_OUT_OE)
    else $error("serial output enabled while deselected");
  a_wr_takes: assert property ((CE && wr_en && hdr_q.addr[4:0] == smp_pkg::REG_ROUTE)
    |=> regs_q[smp_pkg::REG_ROUTE] == $past(wr_data))
    else $error("write to route register not stored");
  a_ro_hold: assert property ((CE && wr_en && hdr_q.addr[4:0] == smp_pkg::REG_LOOP)
    |=> regs_q[smp_pkg::REG_LOOP] == $past(loop_word))
    else $error("read-only readback changed by host write");

  // Lock detector on the sampled phase-detector edges
  logic ahr_q, ahr_d, ahf_q, ahf_d, slip, stall, stall_err;
  logic [2:0] slip_cnt_q, slip_cnt_d;
  logic [9:0] hold_q, hold_d;
  logic [15:0] idle_q, idle_d;
  logic [8:0] pat_q, pat_d;
  assign slip = (ref_e & ~fb_e & ahr_q) | (fb_e & ~ref_e & ahf_q);
  assign stall = (idle_q == smp_pkg::STALL_CYC);
  assign stall_err = stall & regs_q[smp_pkg::REG_CFG][smp_pkg::CFG_SMART_EN] &
                     regs_q[smp_pkg::REG_CFG][smp_pkg::CFG_STALL_ERR];
  always_comb begin
    ahr_d = ahr_q;
    ahf_d = ahf_q;
    slip_cnt_d = slip_cnt_q;
    hold_d = hold_q;
    idle_d = idle_q;
    pat_d = stall_err ? 9'(pat_q + 9'h001) : 9'h000;
    // Phase balance: one edge ahead is normal, a second is a slip
    if (ref_e && !fb_e) begin
      ahf_d = 1'b0;
      ahr_d = ~ahf_q | ahr_q;
    end else if (fb_e && !ref_e) begin
      ahr_d = 1'b0;
      ahf_d = ~ahr_q | ahf_q;
    end
    if (ref_e && hold_q != 10'h000) begin
      hold_d = 10'(hold_q - 10'h001);
    end
    if (slip) begin
      if (slip_cnt_q == smp_pkg::SLIP_LIMIT) begin
        slip_cnt_d = 3'h0;
        hold_d = smp_pkg::UNLOCK_HOLD;
      end else begin
        slip_cnt_d = 3'(slip_cnt_q + 3'h1);
      end
    end
    idle_d = ref_e ? 16'h0000 : (stall ? idle_q : 16'(idle_q + 16'h0001));
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ahr_q <= 1'b0;
      ahf_q <= 1'b0;
      slip_cnt_q <= 3'h0;
      hold_q <= 10'h000;
      idle_q <= 16'h0000;
      pat_q <= 9'h000;
    end else if (CE) begin
      ahr_q <= ahr_d;
      ahf_q <= ahf_d;
      slip_cnt_q <= slip_cnt_d;
      hold_q <= hold_d;
      idle_q <= idle_d;
      pat_q <= pat_d;
    end
  end
  a_slip_trip: assert property ((CE && slip && slip_cnt_q == smp_pkg::SLIP_LIMIT)
    |=> (hold_q == smp_pkg::UNLOCK_HOLD && slip_cnt_q == 3'h0))
    else $error("slip limit did not raise unlock and clear count");

  // Vitals, readback and status pins
  logic [2:0] en_a, en_b;
  logic st_a_d, st_b_d, st_a_q, st_b_q;
  assign en_a = regs_q[smp_pkg::REG_ROUTE][smp_pkg::RT_A_SEL:smp_pkg::RT_A_ULK];
  assign en_b = regs_q[smp_pkg::REG_ROUTE][smp_pkg::RT_B_SEL:smp_pkg::RT_B_ULK];
  always_comb begin
    vit_d.ref_sel = rsel_s;
    vit_d.ref_loss = rlos_s | ~regs_q[smp_pkg::REG_CFG][smp_pkg::CFG_SEC_EN] |
                     (stall & regs_q[smp_pkg::REG_CFG][smp_pkg::CFG_SMART_EN]);
    vit_d.unlock = stall_err ? (pat_q == smp_pkg::STALL_PAT_LOW) :
                   (hold_q != 10'h000);
    st_a_d = |(en_a & {vit_q.ref_sel, vit_q.ref_loss, ~vit_q.unlock});
    st_b_d = |(en_b & {vit_q.ref_sel, vit_q.ref_loss, ~vit_q.unlock});
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      vit_q <= '0;
      st_a_q <= 1'b0;
      st_b_q <= 1'b0;
    end else if (CE) begin
      vit_q <= vit_d;
      st_a_q <= st_a_d;
      st_b_q <= st_b_d;
    end
  end
  a_loss_nosec: assert property ((CE && !regs_q[smp_pkg::REG_CFG][smp_pkg::CFG_SEC_EN])
    |=> vit_q.ref_loss)
    else $error("loss vital low with secondary input disabled");
  a_pin_b_ulk: assert property ((CE && en_b == 3'b001 && $past(en_b) == 3'b001) |=>
    STATUS_OUT_B == !$past(vit_q.unlock, 2))
    else $error("status b not inverted unlock");
  a_pin_a_or: assert property ((CE && en_a == 3'b110 && $past(en_a) == 3'b110) |=>
    STATUS_OUT_A == ($past(vit_q.ref_sel, 2) || $past(vit_q.ref_loss, 2)))
    else $error("status a not OR of enabled vitals");
  a_pin_mode: assert property (CE |=> PIN_MODE == ($past(mode_q) == smp_pkg::MODE_PIN))
    else $error("pin mode flag wrong");

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SERIAL_OUT <= 1'b0;
      SERIAL_OUT_OE <= 1'b0;
      STATUS_OUT_A <= 1'b0;
      STATUS_OUT_B <= 1'b0;
      SPI_MODE <= 1'b0;
      TWO_WIRE_MODE <= 1'b0;
      PIN_MODE <= 1'b0;
      PRESET_CFG <= 5'h00;
      PRESCALER_B_MAP <= 8'h00;
    end else if (CE) begin
      SERIAL_OUT <= sdo_d;
      SERIAL_OUT_OE <= oe_d & ~scs_s;
      STATUS_OUT_A <= st_a_q;
      STATUS_OUT_B <= st_b_q;
      SPI_MODE <= (mode_q == smp_pkg::MODE_SPI);
      TWO_WIRE_MODE <= (mode_q == smp_pkg::MODE_TWI);
      PIN_MODE <= (mode_q == smp_pkg::MODE_PIN);
      PRESET_CFG <= preset_q;
      PRESCALER_B_MAP <= smp_pkg::PSB_MAP;
    end
  end
endmodule

/* sim/smp_host_model.sv */
// Serial host model: shifts frames MSB first and samples returned data
`timescale 1ns/10ps
module smp_host_model (
  output logic sclk,
  output logic ssel_n,
  output logic serial_in,
  input wire logic serial_out
);
  // Link clock stands low and select high between frames
  initial begin
    sclk = 1'b0;
    ssel_n = 1'b1;
    serial_in = 1'b0;
  end
  // One frame of nb bits; rd holds the bits seen after the header
  task automatic xfer(input logic rw, input logic [3:0] dev, input logic [10:0] adr,
                      input logic [31:0] wd, input int nb, output logic [31:0] rd);
    logic [47:0] sh;
    sh = {rw, dev, adr, wd};
    rd = 32'h0;
    ssel_n = 1'b0;
    #62.5;
    for (int i = 0; i < nb; i++) begin
      serial_in = sh[47 - i];
      #62.5 sclk = 1'b1;
      if (i >= 16) rd[47 - i] = serial_out;
      #62.5 sclk = 1'b0;
    end
    #62.5 ssel_n = 1'b1;
    serial_in = ~serial_in;
    #500;
  endtask
endmodule

/* sim/smp_status_port_test.sv */
// Self-checking bench for the status pins and serial register port
`timescale 1ns/10ps
module smp_status_port_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] port_sel = 2'h0;
  logic [4:0] preset = 5'h00;
  logic pfd_ref = 1'b0;
  logic fb_run = 1'b1;
  logic ref_run = 1'b1;
  logic ref_sel = 1'b0;
  logic ref_loss = 1'b0;
  logic sdo_last = 1'b0;
  logic oe_seen = 1'b0;
  logic sclk, ssel_n, serial_in, serial_out, oe, st_a, st_b, m_spi, m_twi, m_pin;
  logic [4:0] pcfg;
  logic [7:0] psb;
  logic [31:0] rd;
  logic [15:0] r3, r4;
  wire sdo_w;
  wire pfd_fb;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // Clock, phase clocks, released data line as inverse of last bit
  always #5 clk = ~clk;
  always @(negedge clk) pfd_ref <= cyc[1] & ref_run;
  assign pfd_fb = fb_run & pfd_ref;
  assign sdo_w = oe ? serial_out : ~sdo_last;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (oe) begin
      sdo_last <= serial_out;
      oe_seen <= 1'b1;
    end
    if (cyc == 60000) begin
      n_fail++;
      conclude();
    end
  end
  smp_status_port smp_status_port_inst (.CLK(clk), .RESET(reset), .CE(1'b1),
    .SERIAL_CLOCK(sclk), .SERIAL_SELECT(ssel_n), .SERIAL_IN(serial_in), .SERIAL_OUT(serial_out),
    .SERIAL_OUT_OE(oe), .HOST_PORT_SEL(port_sel), .PRESET_SELECT_PINS(preset),
    .PFD_REF_IN(pfd_ref), .PFD_FB_IN(pfd_fb), .REF_SELECT_IN(ref_sel),
    .REF_LOSS_IN(ref_loss), .STATUS_OUT_A(st_a), .STATUS_OUT_B(st_b), .SPI_MODE(m_spi),
    .TWO_WIRE_MODE(m_twi), .PIN_MODE(m_pin), .PRESET_CFG(pcfg), .PRESCALER_B_MAP(psb));
  smp_host_model host_inst (.sclk(sclk), .ssel_n(ssel_n), .serial_in(serial_in), .serial_out(sdo_w));
  // Expected pin level from enables, vitals and lock state
  function automatic logic pin(input logic [2:0] en, input logic ul);
    return (en[2] & ref_sel) | (en[1] & (ref_loss | ~r4[smp_pkg::CFG_SEC_EN])) | (en[0] & ~ul);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    host_inst.xfer(1'b0, smp_pkg::DEV_ADDR, a, {d, 16'h0000}, 32, rd);
  endtask
  task automatic rdr(input logic [10:0] a, input logic [15:0] e, input string msg);
    host_inst.xfer(1'b1, smp_pkg::DEV_ADDR, a, 32'h0, 32, rd);
    check(rd[31:16], e, msg);
  endtask
  task automatic conclude;
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    r4 = 16'h0000;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(psb), 16'h00cc, "prescaler map");
    check(16'({m_spi, m_twi, m_pin}), 16'h0004, "serial mode");
    rdr(11'(smp_pkg::REG_ROUTE), 16'h0000, "route reset");
    wr(11'h01f, 16'ha5c3);
    rdr(11'h01f, 16'ha5c3, "last register");
    wr(11'(smp_pkg::REG_LOOP), 16'hffff);
    rdr(11'(smp_pkg::REG_LOOP), 16'h0002, "readback forced loss");
    r4 = 16'h0020;
    wr(11'(smp_pkg::REG_CFG), r4);
    @(negedge clk);
    ref_sel = 1'b1;
    rdr(11'(smp_pkg::REG_LOOP), 16'h0001, "readback select");
    // Every routing bit alone, two OR pairs, and all clear
    for (int k = 0; k < 9; k++) begin
      r3 = (k < 6) ? (16'h0080 << k) : (k == 6) ? 16'h1800 : (k == 7) ? 16'h0180 : 16'h0000;
      wr(11'(smp_pkg::REG_ROUTE), r3);
      for (int v = 0; v < 4; v++) begin
        @(negedge clk);
        {ref_sel, ref_loss} = 2'(v);
        repeat (8) @(negedge clk);
        check(16'(st_a), 16'(pin(r3[12:10], 1'b0)), "pin a");
        check(16'(st_b), 16'(pin(r3[9:7], 1'b0)), "pin b");
      end
    end
    // Wrong fixed bits or an aborted frame: no write and no drive
    oe_seen = 1'b0;
    host_inst.xfer(1'b0, 4'h1, 11'(smp_pkg::REG_ROUTE), 32'h12340000, 32, rd);
    host_inst.xfer(1'b1, 4'h1, 11'(smp_pkg::REG_ROUTE), 32'h0, 32, rd);
    check(16'(oe_seen), 16'h0000, "foreign frame drove");
    host_inst.xfer(1'b0, smp_pkg::DEV_ADDR, 11'(smp_pkg::REG_ROUTE), 32'h55550000, 24, rd);
    rdr(11'(smp_pkg::REG_ROUTE), 16'h0000, "foreign or aborted write");
    repeat (8) @(negedge clk);
    check(16'(oe), 16'h0000, "output enabled when idle");
    // Block write and block read of two words
    host_inst.xfer(1'b0, smp_pkg::DEV_ADDR, 11'h006, 32'h11112222, 48, rd);
    host_inst.xfer(1'b1, smp_pkg::DEV_ADDR, 11'h006, 32'h0, 48, rd);
    check(rd[31:16], 16'h1111, "block word 0");
    check(rd[15:0], 16'h2222, "block word 1");
    // Cycle slips: stop the feedback clock
    wr(11'(smp_pkg::REG_ROUTE), 16'h0480);
    @(negedge clk);
    fb_run = 1'b0;
    repeat (60) @(negedge clk);
    check(16'({st_a, st_b}), 16'h0000, "lock pins unlocked");
    rdr(11'(smp_pkg::REG_LOOP), 16'h0007, "readback unlock");
    @(negedge clk);
    fb_run = 1'b1;
    repeat (3000) @(negedge clk);
    check(16'(st_a), 16'h0000, "unlock hold");
    repeat (1500) @(negedge clk);
    check(16'({st_a, st_b}), 16'h0003, "relock");
    // Both references stalled with smart selector: loss forced high
    r4 = 16'h0060;
    wr(11'(smp_pkg::REG_CFG), r4);
    wr(11'(smp_pkg::REG_ROUTE), 16'h0800);
    @(negedge clk);
    ref_loss = 1'b0;
    repeat (8) @(negedge clk);
    check(16'(st_a), 16'h0000, "loss low before stall");
    ref_run = 1'b0;
    repeat (300) @(negedge clk);
    check(16'(st_a), 16'h0001, "stall forces loss");
    ref_run = 1'b1;
    // Pin mode and two-wire mode selection
    port_sel = 2'h2;
    preset = 5'h15;
    repeat (8) @(negedge clk);
    check(16'({m_spi, m_twi, m_pin}), 16'h0001, "pin mode");
    check(16'(pcfg), 16'h0015, "preset latched");
    port_sel = 2'h1;
    repeat (8) @(negedge clk);
    check(16'({m_spi, m_twi, m_pin}), 16'h0002, "two-wire mode");
    conclude();
  end
endmodule
